/* verilog/driver_pkg.sv */
// Shared constants for the octal serial driver link and its host.
// Assumes a 100 MHz core clock on both ends.
package driver_pkg;

   // ***********************************************************
   // Widths
   // ***********************************************************
   localparam int CHANNELS = 8;
   localparam int CNT_W    = 16;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int CORE_NS        = 10;
   localparam int CORE_MHZ       = 1000 / CORE_NS;
   localparam int BLANK_US       = 160;
   localparam int BLANK_MIN_US   = 75;
   localparam int BLANK_MAX_US   = 250;
   localparam int BLANK_CYCLES   = BLANK_US * CORE_MHZ;
   localparam int CHECK_WAIT_US  = 160;
   localparam int CHECK_CYCLES   = CHECK_WAIT_US * CORE_MHZ;
   localparam int LEAD_NS        = 250;
   localparam int LEAD_CYCLES    = (LEAD_NS + CORE_NS - 1) / CORE_NS;
   localparam int HALF_NS        = 250;
   localparam int HALF_CYCLES    = (HALF_NS + CORE_NS - 1) / CORE_NS;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [7:0] DRIVE_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;

endpackage : driver_pkg

/* verilog/spi_link_if.sv */
// Serial link between the microcontroller end and the driver end.
// Assumes the host end makes the shift clock and the select.
interface spi_link_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so_out;
   logic so_oe;
   // The three-state pin is resolved where the link is wired up, from
   // so_out and so_oe; this carrier only passes the result to the host.
   wire  so;

   modport device (
      input  cs_n,
      input  sclk,
      input  si,
      output so_out,
      output so_oe
   );

   modport host (
      output cs_n,
      output sclk,
      output si,
      input  so
   );
endinterface : spi_link_if

/* verilog/bit_sync.sv */
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no word coherence is given.
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   if (W < 1) begin : g_bad_width
      $error("Synchroniser width must be at least one.");
   end

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } sync_t;

   sync_t st_reg;
   sync_t st_next;

   always_comb begin
      st_next.meta = d;
      st_next.held = st_reg.meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.held;
endmodule : bit_sync

/* verilog/driver_end.sv */
// Driver end: shift register on the link clock, latch and blanking
// timer on the core clock.
// Assumes the host keeps the shift clock low around select edges, so
// the shift register and the select-edge logic never see a race.

// Behaviour
// - Serial output driven only while selected.
// - Select fall loads pin levels as diagnostics.
// - Diagnostic bit is one when pin high.
// - Output on shift rise, input on fall.
// - Most significant bit travels first.
// - Zero control bit turns output on.
// - Unlimited bits pass through for daisy chains.
// - Select rise copies shift register to latch.
// - Select rise starts blanking, faults held off.
// - After blanking, faulted on outputs turn off.
// - Reset clears latch, all outputs off.
// - Shift clock ignored while deselected.
// - Host keeps shift clock low at select edges.
// - Open off pin reads as zero.
// - Host checks faults by writing byte twice.
// - Host decodes mismatches as short or open.
// - Blanking lasts between 75 and 250 us.
module driver_end #(
   parameter int unsigned BLANK_CYCLES = driver_pkg::BLANK_CYCLES
) (
   input  wire logic                            core_clk,
   input  wire logic                            rst,
   spi_link_if.device                           link,
   input  wire logic [driver_pkg::CHANNELS-1:0] pin_high,
   output logic      [driver_pkg::CHANNELS-1:0] drive_on
);

   // ***********************************************************
   // Parameter check
   // ***********************************************************
   if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << driver_pkg::CNT_W))
   begin : g_bad_blank
      $error("Blanking count does not fit the timer.");
   end

   // ***********************************************************
   // Types and state
   // ***********************************************************
   typedef struct packed {
      logic started;
   } fall_t;

   typedef struct packed {
      logic [driver_pkg::CHANNELS-1:0] bits;
   } shift_t;

   typedef struct packed {
      logic so;
   } rise_t;

   typedef struct packed {
      logic                            sel_prev;
      logic [driver_pkg::CHANNELS-1:0] diag;
      logic [driver_pkg::CHANNELS-1:0] on;
      logic [driver_pkg::CNT_W-1:0]    blank;
   } core_t;

   fall_t  fall_reg;
   fall_t  fall_next;
   shift_t shift_reg;
   shift_t shift_next;
   rise_t  rise_reg;
   rise_t  rise_next;
   core_t  core_reg;
   core_t  core_next;

   logic                            sel_s;
   logic [driver_pkg::CHANNELS-1:0] level_s;

   // ***********************************************************
   // Synchronisers into the core domain
   // ***********************************************************
   // The select is synchronised as an active-high level, so the
   // synchroniser's reset value matches an idle link and no false
   // select rise reloads the latch just after reset.
   bit_sync #(
      .W (1)
   ) u_cs_sync (
      .clk (core_clk),
      .rst (rst),
      .d   (~link.cs_n),
      .q   (sel_s)
   );

   bit_sync #(
      .W (driver_pkg::CHANNELS)
   ) u_level_sync (
      .clk (core_clk),
      .rst (rst),
      .d   (pin_high),
      .q   (level_s)
   );

   // ***********************************************************
   // Link domain, falling shift-clock edge
   // ***********************************************************
   // The first falling edge of a frame shifts the frozen diagnostic
   // word, so the jam at select fall needs no shift-clock edge of its
   // own. The diagnostic word is stable for the whole frame.
   always_comb begin
      fall_next.started = 1'b1;
      if (!fall_reg.started) begin
         shift_next.bits = {core_reg.diag[driver_pkg::CHANNELS-2:0],
                            link.si};
      end else begin
         shift_next.bits = {shift_reg.bits[driver_pkg::CHANNELS-2:0],
                            link.si};
      end
   end

   always_ff @(negedge link.sclk or posedge rst or posedge link.cs_n)
   begin
      if (rst || link.cs_n) begin
         fall_reg <= '0;
      end else begin
         fall_reg <= fall_next;
      end
   end

   // The shift register itself survives deselect, since the core
   // domain reads it after select rises.
   // Capture input on fall.
   always_ff @(negedge link.sclk or posedge rst) begin
      if (rst) begin
         shift_reg <= '0;
      end else if (!link.cs_n) begin
         shift_reg <= shift_next;
      end
   end

   // ***********************************************************
   // Link domain, rising shift-clock edge
   // ***********************************************************
   always_comb begin
      if (!fall_reg.started) begin
         rise_next.so = core_reg.diag[driver_pkg::CHANNELS-1];
      end else begin
         rise_next.so = shift_reg.bits[driver_pkg::CHANNELS-1];
      end
   end

   always_ff @(posedge link.sclk or posedge rst or posedge link.cs_n)
   begin
      if (rst || link.cs_n) begin
         rise_reg <= '0;
      end else begin
         rise_reg <= rise_next;
      end
   end

   assign link.so_oe  = ~link.cs_n;
   assign link.so_out = rise_reg.so;

   // ***********************************************************
   // Core domain: latch, diagnostics and blanking
   // ***********************************************************
   always_comb begin
      core_next          = core_reg;
      core_next.sel_prev = sel_s;
      if (!sel_s) begin
         core_next.diag = level_s;
      end
      if (!sel_s && core_reg.sel_prev) begin
         core_next.on    = ~shift_reg.bits;
         core_next.blank = driver_pkg::CNT_W'(BLANK_CYCLES);
      end else if (core_reg.blank != '0) begin
         core_next.blank = core_reg.blank - 1'b1;
      end else begin
         core_next.on = core_reg.on & ~level_s;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         core_reg    <= '0;
         core_reg.on <= driver_pkg::DRIVE_RESET;
      end else begin
         core_reg <= core_next;
      end
   end

   assign drive_on = core_reg.on;

endmodule : driver_end

/* verilog/host_end.sv */
// Microcontroller end: runs one byte frame or a two-frame fault check.
// Assumes a single driver on the link and a 100 MHz core clock.
module host_end #(
   parameter int unsigned HALF_CYCLES  = driver_pkg::HALF_CYCLES,
   parameter int unsigned LEAD_CYCLES  = driver_pkg::LEAD_CYCLES,
   parameter int unsigned CHECK_CYCLES = driver_pkg::CHECK_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic       check,
   input  wire logic [7:0] tx_byte,
   output logic            busy,
   output logic            done,
   output logic      [7:0] rx_byte,
   output logic      [7:0] short_flags,
   output logic      [7:0] open_flags,
   spi_link_if.host        link
);

   // ***********************************************************
   // Parameter check
   // ***********************************************************
   // Half periods under three cycles would sample the serial output
   // before it has passed the synchroniser.
   if (HALF_CYCLES < 3 || LEAD_CYCLES < 3 ||
       HALF_CYCLES >= (1 << driver_pkg::CNT_W) ||
       CHECK_CYCLES < LEAD_CYCLES ||
       CHECK_CYCLES >= (1 << driver_pkg::CNT_W)) begin : g_bad_time
      $error("Host timing parameters out of range.");
   end

   // ***********************************************************
   // State
   // ***********************************************************
   typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, LAG, GAP} phase_t;

   typedef struct packed {
      phase_t                       phase;
      logic [driver_pkg::CNT_W-1:0] cnt;
      logic [2:0]                   bit_idx;
      logic [7:0]                   tx;
      logic [7:0]                   sh;
      logic [7:0]                   rx;
      logic                         chk;
      logic                         second;
      logic                         cs_n;
      logic                         sclk;
      logic                         si;
      logic                         done;
      logic [7:0]                   rx_out;
      logic [7:0]                   short_out;
      logic [7:0]                   open_out;
   } host_t;

   host_t st_reg;
   host_t st_next;
   logic  so_s;

   bit_sync #(
      .W (1)
   ) u_so_sync (
      .clk (core_clk),
      .rst (rst),
      .d   (link.so),
      .q   (so_s)
   );

   // ***********************************************************
   // Sequencer
   // ***********************************************************
   // The input bit changes together with the rising edge (the first bit at select
   // fall), at least a half period before the falling edge that captures it.
   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      case (st_reg.phase)
         IDLE: begin
            if (start) begin
               st_next.tx     = tx_byte;
               st_next.sh     = tx_byte;
               st_next.chk    = check;
               st_next.second = 1'b0;
               st_next.rx     = driver_pkg::BYTE_ZERO;
               st_next.cs_n   = 1'b0;
               st_next.si     = tx_byte[7];
               st_next.cnt    = driver_pkg::CNT_W'(LEAD_CYCLES - 1);
               st_next.phase  = LEAD;
            end
         end
         LEAD: begin
            if (st_reg.cnt == '0) begin
               st_next.bit_idx = 3'h0;
               st_next.sclk    = 1'b1;
               st_next.cnt     = driver_pkg::CNT_W'(HALF_CYCLES - 1);
               st_next.phase   = HIGH;
            end else begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         HIGH: begin
            if (st_reg.cnt == '0) begin
               st_next.rx    = {st_reg.rx[6:0], so_s};
               st_next.sclk  = 1'b0;
               st_next.cnt   = driver_pkg::CNT_W'(HALF_CYCLES - 1);
               st_next.phase = LOW;
            end else begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         LOW: begin
            if (st_reg.cnt != '0) begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end else if (st_reg.bit_idx == 3'h7) begin
               st_next.cnt   = driver_pkg::CNT_W'(LEAD_CYCLES - 1);
               st_next.phase = LAG;
            end else begin
               st_next.bit_idx = st_reg.bit_idx + 3'h1;
               st_next.sh      = {st_reg.sh[6:0], 1'b0};
               st_next.si      = st_reg.sh[6];
               st_next.sclk    = 1'b1;
               st_next.cnt     = driver_pkg::CNT_W'(HALF_CYCLES - 1);
               st_next.phase   = HIGH;
            end
         end
         LAG: begin
            if (st_reg.cnt == '0) begin
               st_next.cs_n  = 1'b1;
               st_next.phase = GAP;
               if (st_reg.chk && !st_reg.second) begin
                  st_next.cnt = driver_pkg::CNT_W'(CHECK_CYCLES - 1);
               end else begin
                  st_next.cnt = driver_pkg::CNT_W'(LEAD_CYCLES - 1);
               end
            end else begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         GAP: begin
            if (st_reg.cnt != '0) begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end else if (st_reg.chk && !st_reg.second) begin
               st_next.second = 1'b1;
               st_next.sh     = st_reg.tx;
               st_next.rx     = driver_pkg::BYTE_ZERO;
               st_next.cs_n   = 1'b0;
               st_next.si     = st_reg.tx[7];
               st_next.cnt    = driver_pkg::CNT_W'(LEAD_CYCLES - 1);
               st_next.phase  = LEAD;
            end else begin
               st_next.rx_out    = st_reg.rx;
               st_next.short_out = ~st_reg.tx & st_reg.rx;
               st_next.open_out  = st_reg.tx & ~st_reg.rx;
               st_next.done      = 1'b1;
               st_next.phase     = IDLE;
            end
         end
         default: begin
            st_next.phase = IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg       <= '0;
         st_reg.phase <= IDLE;
         st_reg.cs_n  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy        = (st_reg.phase != IDLE);
   assign done        = st_reg.done;
   assign rx_byte     = st_reg.rx_out;
   assign short_flags = st_reg.short_out;
   assign open_flags  = st_reg.open_out;
   assign link.cs_n   = st_reg.cs_n;
   assign link.sclk   = st_reg.sclk;
   assign link.si     = st_reg.si;

endmodule : host_end

/* verif/octal_link_chk.sv */
// Checker for the link between the host end and the driver end.
// Assumes sclk and cs_n change only on core_clk edges.
module octal_link_chk #(
   parameter int unsigned BLANK_CYCLES = driver_pkg::BLANK_CYCLES
) (
   input  wire logic                            core_clk,
   input  wire logic                            rst,
   input  wire logic                            cs_n,
   input  wire logic                            sclk,
   input  wire logic                            si,
   input  wire logic                            so_oe,
   input  wire logic                            busy,
   input  wire logic                            done,
   input  wire logic [driver_pkg::CHANNELS-1:0] pin_high,
   input  wire logic [driver_pkg::CHANNELS-1:0] drive_on
);
   // Margin covers the pin synchroniser and the latch update.
   localparam int CLEAR_AT = BLANK_CYCLES + 10;

   logic [7:0]  shadow_reg;
   logic [15:0] since_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shadow_reg <= 8'h00;
         since_reg  <= 16'hFFFF;
      end else begin
         if ($fell(sclk) && !cs_n) begin
            shadow_reg <= {shadow_reg[6:0], si};
         end
         if ($rose(cs_n)) begin
            since_reg <= 16'h0000;
         end else if (since_reg != 16'hFFFF) begin
            since_reg <= since_reg + 16'h0001;
         end
      end
   end

   a_oe_select: assert property (so_oe == !cs_n)
      else $error("serial output enable wrong");
   a_sclk_fall_low: assert property ($fell(cs_n) |-> !sclk)
      else $error("shift clock high at select fall");
   a_sclk_rise_low: assert property ($rose(cs_n) |-> !sclk)
      else $error("shift clock high at select rise");
   a_lead_time: assert property ($fell(cs_n) |-> !sclk [*3])
      else $error("shift clock too soon after select");
   a_latch_load: assert property ($rose(cs_n) |->
      ##[1:4] (drive_on == ~shadow_reg))
      else $error("latch not loaded from shifted bits");
   a_blank_hold: assert property ((since_reg >= 5 &&
      since_reg < BLANK_CYCLES) |-> $stable(drive_on))
      else $error("latch changed during blanking");
   a_fault_clear: assert property ((since_reg >= CLEAR_AT) |->
      ((drive_on & pin_high & $past(pin_high, 5)) == 8'h00))
      else $error("faulted output left on");
   a_busy_frame: assert property (!cs_n |-> busy)
      else $error("frame outside a command");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");

   cover property ($rose(cs_n));
   cover property (since_reg == CLEAR_AT && |drive_on);
   cover property ($fell(sclk) && !cs_n && si);
endmodule : octal_link_chk

/* verif/octal_serial_driver_control_tb.sv */
// Testbench: host end and driver end on one link, plus a second
// driver end whose link the bench drives by hand.
module octal_serial_driver_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BLANK = 50;

   logic       core_clk;
   logic       rst;
   logic       start;
   logic       check;
   logic [7:0] tx_byte;
   logic       busy;
   logic       done;
   logic [7:0] rx_byte;
   logic [7:0] short_flags;
   logic [7:0] open_flags;
   logic [7:0] pin_high;
   logic [7:0] drive_on;
   logic [7:0] drive_on_b;
   logic [7:0] open_m;
   logic [7:0] short_m;
   int         fails;
   int         comparisons;

   spi_link_if link_a ();
   spi_link_if link_b ();

   // The serial output pin floats while its driver end is deselected.
   assign link_a.so = link_a.so_oe ? link_a.so_out : 1'bz;
   assign link_b.so = link_b.so_oe ? link_b.so_out : 1'bz;

   host_end #(.HALF_CYCLES(4), .LEAD_CYCLES(4), .CHECK_CYCLES(60))
   i_host_end (.core_clk(core_clk), .rst(rst), .start(start),
      .check(check), .tx_byte(tx_byte), .busy(busy), .done(done),
      .rx_byte(rx_byte), .short_flags(short_flags),
      .open_flags(open_flags), .link(link_a));
   driver_end #(.BLANK_CYCLES(BLANK)) i_driver_end (.core_clk(core_clk),
      .rst(rst), .link(link_a), .pin_high(pin_high), .drive_on(drive_on));
   driver_end #(.BLANK_CYCLES(BLANK)) i_driver_end_b (.core_clk(core_clk),
      .rst(rst), .link(link_b), .pin_high(8'h96), .drive_on(drive_on_b));
   octal_link_chk #(.BLANK_CYCLES(BLANK)) i_octal_link_chk (
      .core_clk(core_clk), .rst(rst), .cs_n(link_a.cs_n),
      .sclk(link_a.sclk), .si(link_a.si), .so_oe(link_a.so_oe),
      .busy(busy), .done(done), .pin_high(pin_high), .drive_on(drive_on));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Loads pull off pins high, an open pin reads low, a short keeps
   // an on pin high.
   always @(negedge core_clk) begin
      pin_high <= (~drive_on & ~open_m) | (drive_on & short_m);
   end

   task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check_eq

   task automatic report_and_stop();
      if (fails == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic host_cmd(input logic mode, input logic [7:0] value);
      int n;
      n = 0;
      @(negedge core_clk);
      start = 1'b1;
      check = mode;
      tx_byte = value;
      @(negedge core_clk);
      start = 1'b0;
      while (done !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 2000) begin
         fails++;
      end
   endtask : host_cmd

   task automatic test_write();
      check_eq(drive_on, 8'h00);
      check_eq({7'h00, link_a.so}, {7'h00, 1'bz});
      host_cmd(1'b0, 8'h5A);
      check_eq(rx_byte, 8'hFF);
      repeat (4) @(negedge core_clk);
      check_eq(drive_on, 8'hA5);
      host_cmd(1'b0, 8'h5A);
      check_eq(rx_byte, 8'h5A);
   endtask : test_write

   task automatic test_faults();
      open_m = 8'h02;
      short_m = 8'h04;
      host_cmd(1'b1, 8'h5A);
      check_eq(rx_byte, 8'h5C);
      check_eq(short_flags, 8'h04);
      check_eq(open_flags, 8'h02);
      check_eq(drive_on, 8'hA5);
      repeat (BLANK + 20) @(negedge core_clk);
      check_eq(drive_on, 8'hA1);
   endtask : test_faults

   // The bench stands in for a host here so that more than one byte
   // can pass through the shift register. The input bit changes with
   // the rising clock, half a period clear of the capturing fall.
   task automatic test_chain();
      logic [15:0] word;
      logic [15:0] seen;
      word = 16'h3CC3;
      seen = 16'h0000;
      check_eq({7'h00, link_b.so}, {7'h00, 1'bz});
      check_eq(drive_on_b, 8'h00);
      link_b.cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (8) @(negedge core_clk);
         link_b.si = word[i];
         link_b.sclk = 1'b1;
         repeat (8) @(negedge core_clk);
         seen[i] = link_b.so;
         link_b.sclk = 1'b0;
      end
      repeat (8) @(negedge core_clk);
      link_b.cs_n = 1'b1;
      repeat (6) @(negedge core_clk);
      check_eq(seen[15:8], 8'h96);
      check_eq(seen[7:0], word[15:8]);
      check_eq(drive_on_b, ~word[7:0]);
      repeat (BLANK + 20) @(negedge core_clk);
      check_eq(drive_on_b, ~word[7:0] & 8'h69);
      // Clock edges while deselected must leave the shift register
      // alone; an empty frame then copies it into the latch again.
      for (int i = 0; i < 6; i++) begin
         repeat (4) @(negedge core_clk);
         link_b.sclk = ~link_b.sclk;
         link_b.si = ~link_b.si;
      end
      check_eq({7'h00, link_b.so}, {7'h00, 1'bz});
      repeat (4) @(negedge core_clk);
      link_b.cs_n = 1'b0;
      repeat (8) @(negedge core_clk);
      link_b.cs_n = 1'b1;
      repeat (6) @(negedge core_clk);
      check_eq(drive_on_b, ~word[7:0]);
   endtask : test_chain

   task automatic test_midreset();
      rst = 1'b1;
      repeat (3) @(negedge core_clk);
      check_eq(drive_on, 8'h00);
      check_eq(drive_on_b, 8'h00);
      rst = 1'b0;
      // No false select edge may reload the latch once reset is gone.
      repeat (8) @(negedge core_clk);
      check_eq(drive_on, 8'h00);
      check_eq(drive_on_b, 8'h00);
      host_cmd(1'b0, 8'hF0);
      check_eq(rx_byte, 8'hFD);
      repeat (4) @(negedge core_clk);
      check_eq(drive_on, 8'h0F);
   endtask : test_midreset

   initial begin
      rst = 1'b1;
      start = 1'b0;
      check = 1'b0;
      tx_byte = 8'h00;
      open_m = 8'h00;
      short_m = 8'h00;
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.si = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      test_write();
      test_faults();
      test_chain();
      test_midreset();
      report_and_stop();
   end

   // Limit is several times the expected run length.
   initial begin
      repeat (6000) @(posedge core_clk);
      fails++;
      report_and_stop();
   end
endmodule : octal_serial_driver_control_tb
